// ### design/rtc_trim_map.vh
// Purpose: Register offsets, field positions and counts of the trim block.
// Assumes: Included by bare name from the trim design files.
// Notes: Definitions only.
`ifndef RTC_TRIM_MAP_VH
`define RTC_TRIM_MAP_VH

`define TWO_DAY_TRIM_ADDR 8'h10
`define EIGHT_SEC_TRIM_ADDR 8'h12
`define TWO_DAY_CODE_MSB 4
`define TWO_DAY_CODE_W 5
`define TWO_DAY_RESET 5'h00
`define EIGHT_SEC_RESET 8'h00
`define READ_ZERO 8'h00
`define CRYSTAL_TICKS_PER_SEC 32768
`define SD_SLOT_BITS 10
`define SD_ACC_W 8

`endif

// ### design/sigma_delta_trim.v
// Purpose: Spreads the eight-second trim as extra or dropped crystal ticks.
// Assumes: Tick input is a one-cycle pulse on the core clock, far apart.
// Notes: Each 8 s window holds 256 slots; the accumulator adds the trim magnitude per slot.
`timescale 1ns/100ps
`include "rtc_trim_map.vh"
module sigma_delta_trim #(
  parameter SLOT_BITS = `SD_SLOT_BITS,
  parameter ACC_W = `SD_ACC_W
) (
  input wire core_clk_in,
  input wire arst_n_in,
  input wire tick_in,
  input wire [7:0] trim_in,
  output reg tick_out
);
  reg [SLOT_BITS-1:0] slot_cnt_q;
  reg [ACC_W-1:0] acc_q;
  reg pend_q;
  wire [7:0] mag;
  wire [ACC_W:0] acc_sum;
  wire slot_end;
  wire fire;

  // Trim is signed; the magnitude drives the modulator, the sign picks add or drop.
  assign mag = trim_in[7] ? (8'h00 - trim_in) : trim_in;
  assign slot_end = tick_in && (slot_cnt_q == {SLOT_BITS{1'b1}});
  assign acc_sum = {1'b0, acc_q} + {1'b0, mag[ACC_W-1:0]};
  assign fire = slot_end && acc_sum[ACC_W] && (trim_in != 8'h00);

  always @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      slot_cnt_q <= {SLOT_BITS{1'b0}};
      acc_q <= {ACC_W{1'b0}};
      pend_q <= 1'b0;
      tick_out <= 1'b0;
    end else begin
      tick_out <= 1'b0;
      if (pend_q) begin
        tick_out <= 1'b1;
        pend_q <= 1'b0;
      end
      if (tick_in) begin
        slot_cnt_q <= slot_cnt_q + {{(SLOT_BITS-1){1'b0}}, 1'b1};
        if (slot_end) begin
          acc_q <= acc_sum[ACC_W-1:0];
        end
        // One tick is inserted or dropped per accumulator carry over the 8 s window.
        if (fire && trim_in[7]) begin
          tick_out <= 1'b0;
        end else begin
          tick_out <= 1'b1;
          if (fire) begin
            pend_q <= 1'b1;
          end
        end
      end
    end
  end
endmodule // sigma_delta_trim

// ### design/rtc_frequency_trim.v
// Purpose: Oscillator frequency trimming for the real-time clock seconds chain.
// Assumes: Crystal tick arrives as a level from outside; calendar flags 00:00:30 on this clock.
// Notes: Trim registers reset to zero so the chain starts untrimmed.
//
// How it works
// - Two-day trim register holds signed five-bit code.
// - Upper three bits ignore writes, read zero.
// - Day one gets N/2, day two the rest.
// - Day one and day two alternate forever.
// - Daily correction only at midnight plus thirty seconds.
// - Negative correction discards that many second ticks.
// - Zero code gives no correction either day.
// - Eight-second trim register spreads corrections sigma-delta.
// - All eight bits form the trim value.
// - Signed value raises or lowers frequency proportionally.
`timescale 1ns/100ps
`include "rtc_trim_map.vh"
module rtc_frequency_trim #(
  parameter TICKS_PER_SEC = `CRYSTAL_TICKS_PER_SEC
) (
  input wire core_clk_in,
  input wire arst_n_in,
  input wire osc_level_in,
  input wire at_adjust_time_in,
  input wire [7:0] reg_addr_in,
  input wire [7:0] reg_wdata_in,
  input wire reg_wr_in,
  output reg [7:0] reg_rdata_out,
  output reg sec_step_out,
  output reg day_two_out
);
  reg [`TWO_DAY_CODE_MSB:0] two_day_q;
  reg [7:0] eight_sec_q;
  reg osc_s1_q;
  reg osc_s2_q;
  reg osc_s3_q;
  reg osc_lvl_q;
  reg osc_tick_q;
  reg [15:0] div_q;
  reg done_q;
  reg [4:0] drop_q;
  reg [4:0] add_q;
  reg add_gap_q;
  wire trimmed_tick;
  wire sec_tick;
  wire apply_now;
  wire signed [5:0] today_corr;
  wire [4:0] today_mag;

  // Day-one correction is the code halved and truncated toward zero.
  // Negative codes get one added before the sign-keeping halving, so it rounds toward zero.
  function signed [5:0] day_one_corr;
    input [4:0] code;
    reg [5:0] t;
    begin
      t = {code[4], code} + {5'h00, code[4]};
      day_one_corr = {t[5], t[5:1]};
    end
  endfunction

  function [4:0] mag6;
    input signed [5:0] v;
    reg [5:0] a;
    begin
      a = v[5] ? (6'h00 - v) : v;
      mag6 = a[4:0];
    end
  endfunction

  // Day two takes whatever the code leaves after day one.
  assign today_corr = day_two_out ?
    ({two_day_q[4], two_day_q} - day_one_corr(two_day_q)) : day_one_corr(two_day_q);
  assign today_mag = mag6(today_corr);

  // Registers are written through the documented offsets only.
  always @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      two_day_q <= `TWO_DAY_RESET;
      eight_sec_q <= `EIGHT_SEC_RESET;
    end else if (reg_wr_in) begin
      if (reg_addr_in == `TWO_DAY_TRIM_ADDR) begin
        two_day_q <= reg_wdata_in[`TWO_DAY_CODE_MSB:0];
      end
      if (reg_addr_in == `EIGHT_SEC_TRIM_ADDR) begin
        eight_sec_q <= reg_wdata_in;
      end
    end
  end

  // Read data follows the address one cycle later; top bits of 10h read zero.
  always @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      reg_rdata_out <= `READ_ZERO;
    end else if (reg_addr_in == `TWO_DAY_TRIM_ADDR) begin
      reg_rdata_out <= {3'h0, two_day_q};
    end else if (reg_addr_in == `EIGHT_SEC_TRIM_ADDR) begin
      reg_rdata_out <= eight_sec_q;
    end else begin
      reg_rdata_out <= `READ_ZERO;
    end
  end

  // The crystal level passes three flops; a rising change counts once stages two and three agree.
  always @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      osc_s1_q <= 1'b0;
      osc_s2_q <= 1'b0;
      osc_s3_q <= 1'b0;
      osc_lvl_q <= 1'b0;
      osc_tick_q <= 1'b0;
    end else begin
      osc_s1_q <= osc_level_in;
      osc_s2_q <= osc_s1_q;
      osc_s3_q <= osc_s2_q;
      osc_tick_q <= 1'b0;
      if (osc_s2_q == osc_s3_q) begin
        osc_lvl_q <= osc_s3_q;
        osc_tick_q <= osc_s3_q && !osc_lvl_q;
      end
    end
  end

  // The eight-second trim acts on crystal ticks, ahead of and apart from the daily one.
  sigma_delta_trim #(
    .SLOT_BITS(`SD_SLOT_BITS),
    .ACC_W(`SD_ACC_W)
  ) u_sd (
    .core_clk_in(core_clk_in),
    .arst_n_in(arst_n_in),
    .tick_in(osc_tick_q),
    .trim_in(eight_sec_q),
    .tick_out(trimmed_tick)
  );

  assign sec_tick = trimmed_tick && (div_q == TICKS_PER_SEC - 1);

  always @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      div_q <= 16'h0000;
    end else if (trimmed_tick) begin
      if (div_q == TICKS_PER_SEC - 1) begin
        div_q <= 16'h0000;
      end else begin
        div_q <= div_q + 16'h0001;
      end
    end
  end

  // The daily correction is taken once, on the first second seen at 00:00:30.
  assign apply_now = sec_tick && at_adjust_time_in && !done_q;

  always @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      done_q <= 1'b0;
      day_two_out <= 1'b0;
      drop_q <= 5'h00;
      add_q <= 5'h00;
      add_gap_q <= 1'b0;
      sec_step_out <= 1'b0;
    end else begin
      sec_step_out <= 1'b0;
      add_gap_q <= 1'b0;
      if (!at_adjust_time_in && drop_q == 5'h00) begin
        done_q <= 1'b0;
      end
      if (apply_now) begin
        done_q <= 1'b1;
        day_two_out <= !day_two_out;
        if (today_corr[5]) begin
          // Negative: this and the next ticks are swallowed, holding the seconds.
          drop_q <= today_mag - 5'h01;
        end else begin
          // Positive: this second counts, then extra steps follow one by one.
          sec_step_out <= 1'b1;
          add_q <= today_mag;
          add_gap_q <= 1'b1;
        end
        // A zero code leaves both counters at zero, so nothing changes.
      end else if (sec_tick) begin
        if (drop_q != 5'h00) begin
          drop_q <= drop_q - 5'h01;
        end else begin
          sec_step_out <= 1'b1;
          add_gap_q <= 1'b1;
        end
      end else if (add_q != 5'h00 && !add_gap_q) begin
        // Extra steps are spaced by an idle cycle so the calendar sees each carry.
        sec_step_out <= 1'b1;
        add_gap_q <= 1'b1;
        add_q <= add_q - 5'h01;
      end
    end
  end
endmodule // rtc_frequency_trim

// ### dv/trim_asserts.sv
// Purpose: Port checker for the trim block.
// Assumes: Bound to rtc_frequency_trim.
// Notes: One clock domain.
`timescale 1ns/100ps
module trim_asserts (
  input wire core_clk_in,
  input wire arst_n_in,
  input wire at_adjust_time_in,
  input wire [7:0] reg_addr_in,
  input wire [7:0] reg_wdata_in,
  input wire reg_wr_in,
  input wire [7:0] reg_rdata_out,
  input wire sec_step_out,
  input wire day_two_out
);
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!arst_n_in);
  hi_bits_zero_a: assert property ($past(reg_addr_in) == 8'h10 |-> reg_rdata_out[7:5] == 3'h0)
    else $error("upper bits not zero");
  unmapped_zero_a: assert property ($past(reg_addr_in) != 8'h10 && $past(reg_addr_in) != 8'h12
    |-> reg_rdata_out == 8'h00) else $error("unmapped read not zero");
  two_day_wb_a: assert property (reg_wr_in && reg_addr_in == 8'h10 ##1 !reg_wr_in && reg_addr_in == 8'h10
    |=> reg_rdata_out == {3'h0, $past(reg_wdata_in[4:0], 2)}) else $error("two-day readback wrong");
  eight_sec_wb_a: assert property (reg_wr_in && reg_addr_in == 8'h12 ##1 !reg_wr_in && reg_addr_in == 8'h12
    |=> reg_rdata_out == $past(reg_wdata_in, 2)) else $error("eight-second readback wrong");
  read_steady_a: assert property (!reg_wr_in && !$past(reg_wr_in) && $stable(reg_addr_in)
    |=> $stable(reg_rdata_out)) else $error("read data moved");
  step_single_a: assert property (sec_step_out |=> !sec_step_out) else $error("step pulse too long");
  day_at_adjust_a: assert property ($changed(day_two_out) |-> $past(at_adjust_time_in))
    else $error("day parity moved off adjust time");
  day_hold_a: assert property ($changed(day_two_out) |=> $stable(day_two_out) [*8])
    else $error("day parity toggled twice");
  cover property (sec_step_out ##2 sec_step_out);
  cover property ($changed(day_two_out));
  cover property (reg_wr_in && reg_addr_in == 8'h12);
endmodule // trim_asserts
bind rtc_frequency_trim trim_asserts chk (.core_clk_in, .arst_n_in, .at_adjust_time_in, .reg_addr_in,
  .reg_wdata_in, .reg_wr_in, .reg_rdata_out, .sec_step_out, .day_two_out);

// ### dv/osc_model.sv
// Purpose: Crystal model giving a free-running square wave.
// Assumes: Period is 20 core clocks, phase offset from the clock.
// Notes: Runs free, as a crystal does.
`timescale 1ns/100ps
module osc_model (
  output reg osc_level_out
);
  initial begin
    osc_level_out = 1'b0;
    #37;
    forever #1000 osc_level_out = ~osc_level_out;
  end
endmodule // osc_model

// ### dv/testbench.sv
// Purpose: Register and daily correction tests of the trim block.
// Assumes: Four ticks per second, so one second is 80 clocks.
// Notes: A 16 second span is counted with and without the adjust flag; a long span checks the 8 s trim.
`timescale 1ns/100ps
module testbench;
  reg core_clk_in = 1'b0;
  reg arst_n_in = 1'b0;
  reg at_adjust_time_in = 1'b0;
  reg [7:0] reg_addr_in = 8'h00;
  reg [7:0] reg_wdata_in = 8'h00;
  reg reg_wr_in = 1'b0;
  reg par = 1'b0;
  reg [4:0] codes [0:4];
  reg [7:0] c;
  reg [15:0] sd_cnt;
  wire osc_level;
  wire [7:0] reg_rdata_out;
  wire sec_step_out;
  wire day_two_out;
  integer err_count = 0;
  integer total_checks = 0;
  integer steps = 0;
  integer i;
  integer n;
  integer d1;
  always #50 core_clk_in = ~core_clk_in;
  osc_model osc (.osc_level_out(osc_level));
  rtc_frequency_trim #(.TICKS_PER_SEC(4)) uut (.core_clk_in(core_clk_in), .arst_n_in(arst_n_in),
    .osc_level_in(osc_level), .at_adjust_time_in(at_adjust_time_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rdata_out(reg_rdata_out),
    .sec_step_out(sec_step_out), .day_two_out(day_two_out));
  always @(posedge core_clk_in) if (sec_step_out === 1'b1) steps = steps + 1;
  task tally_and_finish;
    begin
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) begin
        $display("*** PASS ***");
      end else begin
        $display("*** FAIL ***");
      end
      $finish;
    end
  endtask
  task cmp(input [15:0] got, input [15:0] exp);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(posedge core_clk_in);
      reg_addr_in <= a;
      reg_wdata_in <= d;
      reg_wr_in <= 1'b1;
      @(posedge core_clk_in);
      reg_wr_in <= 1'b0;
    end
  endtask
  task rd_cmp(input [7:0] a, input [7:0] exp);
    begin
      @(posedge core_clk_in);
      reg_addr_in <= a;
      @(posedge core_clk_in);
      @(negedge core_clk_in);
      cmp(reg_rdata_out, exp);
    end
  endtask
  task span(input adj, output [7:0] cnt);
    begin
      @(posedge core_clk_in);
      at_adjust_time_in <= adj;
      @(negedge core_clk_in);
      steps = 0;
      repeat (1280) @(negedge core_clk_in);
      cnt = steps;
      @(posedge core_clk_in);
      at_adjust_time_in <= 1'b0;
    end
  endtask
  task sd_span(output [15:0] cnt);
    begin
      @(negedge core_clk_in);
      while (sec_step_out !== 1'b1) @(negedge core_clk_in);
      @(negedge core_clk_in);
      steps = 0;
      repeat (40970) @(negedge core_clk_in);
      cnt = steps;
    end
  endtask
  initial begin
    codes[0] = 5'h0F;
    codes[1] = 5'h00;
    codes[2] = 5'h1B;
    codes[3] = 5'h10;
    codes[4] = 5'h01;
    repeat (8) @(posedge core_clk_in);
    arst_n_in <= 1'b1;
    rd_cmp(8'h10, 8'h00);
    rd_cmp(8'h12, 8'h00);
    wr(8'h10, 8'hFB);
    rd_cmp(8'h10, 8'h1B);
    wr(8'h12, 8'hA5);
    rd_cmp(8'h12, 8'hA5);
    wr(8'h11, 8'hFF);
    rd_cmp(8'h11, 8'h00);
    wr(8'h12, 8'h00);
    $display("register test done");
    span(1'b0, c);
    cmp(c, 8'h10);
    cmp({7'h00, day_two_out}, 8'h00);
    $display("baseline test done");
    for (i = 0; i < 10; i = i + 1) begin
      wr(8'h10, {3'h0, codes[i / 2]});
      n = $signed(codes[i / 2]);
      d1 = n / 2;
      span(1'b1, c);
      cmp(c, 8'h10 + (par ? n - d1 : d1));
      par = ~par;
      cmp({7'h00, day_two_out}, {7'h00, par});
    end
    $display("trim test done");
    wr(8'h12, 8'h80);
    sd_span(sd_cnt);
    cmp(sd_cnt, 16'h01FF);
    $display("sigma-delta test done");
    tally_and_finish;
  end
  initial begin
    #7000000;
    err_count = err_count + 1;
    tally_and_finish;
  end
endmodule // testbench
